/* sfc_pkg.sv */
// Purpose: Shared constants and carriers for the serial software flow control block
// Assumes: 8-bit serial characters, one system clock
// Notes: Thresholds give hysteresis on the receive buffer fill level
package sfc_pkg;
   localparam int unsigned BYTE_W = 8;
   localparam logic [7:0] CHAR_PAUSE = 8'h13;
   localparam logic [7:0] CHAR_RESUME = 8'h11;
   localparam int unsigned RXBUF_DEPTH = 64;
   localparam int unsigned LVL_W = 7;
   localparam logic [6:0] RX_HIGH_MARK = 7'h30;
   localparam logic [6:0] RX_LOW_MARK = 7'h10;
   localparam logic [6:0] LVL_ZERO = 7'h00;
   localparam logic [6:0] LVL_ONE = 7'h01;
   localparam logic [1:0] SKID_DEPTH = 2'h2;
   localparam logic [1:0] SKID_ZERO = 2'h0;
   localparam logic [1:0] SKID_ONE = 2'h1;
   localparam logic SKID_IDX_ZERO = 1'h0;
   localparam logic SKID_IDX_ONE = 1'h1;

   typedef enum logic [1:0] {
      SFC_CFG_NONE,
      SFC_CFG_SET,
      SFC_CFG_QUERY
   } sfc_cfg_op_t;

   typedef struct packed {
      sfc_cfg_op_t op;
      logic tx_present;
      logic tx_value;
      logic rx_present;
      logic rx_value;
   } sfc_cfg_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sfc_byte_t;
endpackage : sfc_pkg

/* sfc_skid.sv */
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, asynchronous active-high reset
// Notes: Input ready is high whenever an entry is free
`timescale 1ns/1ns
module sfc_skid
   import sfc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [7:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [7:0] out_data_out,
   input wire logic out_ready_in
);
   typedef struct packed {
      logic [1:0][7:0] mem;
      logic rd;
      logic wr;
      logic [1:0] cnt;
      logic rdy;
   } sfc_skid_state_t;

   sfc_skid_state_t s_q;
   sfc_skid_state_t s_d;
   logic push;
   logic pop;

   // Ready is registered so the block's payload ready pin comes from a flop
   assign in_ready_out = s_q.rdy;
   assign out_valid_out = (s_q.cnt != SKID_ZERO);
   assign out_data_out = s_q.mem[s_q.rd];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data_in;
         s_d.wr = ~s_q.wr;
      end
      if (pop) begin
         s_d.rd = ~s_q.rd;
      end
      if (push && !pop) begin
         s_d.cnt = s_q.cnt + SKID_ONE;
      end else if (pop && !push) begin
         s_d.cnt = s_q.cnt - SKID_ONE;
      end
      s_d.rdy = (s_d.cnt != SKID_DEPTH);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_q <= '0;
         s_q.rdy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : sfc_skid

/* sfc_flow.sv */
// Purpose: XON/XOFF software flow control between transmit path and serial line
// Assumes: One 250 MHz clock, asynchronous active-high reset acting as power-on
// Notes: Received pause/resume characters are consumed only while transmit control is on
`timescale 1ns/1ns

module sfc_flow
   import sfc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Configuration command and online reset
   input wire sfc_cfg_t cfg_in,
   input wire logic online_reset_in,
   output logic query_valid_out,
   output logic query_value_out,
   output logic tx_en_out,
   output logic rx_en_out,
   // Payload from the converter to the serial line
   input wire logic pay_valid_in,
   input wire logic [7:0] pay_data_in,
   output logic pay_ready_out,
   // Serial transmitter
   output logic ser_tx_valid_out,
   output logic [7:0] ser_tx_data_out,
   input wire logic ser_tx_ready_in,
   // Serial receiver
   input wire logic ser_rx_valid_in,
   input wire logic [7:0] ser_rx_data_in,
   // Receive buffer fill level
   input wire logic [6:0] rx_level_in,
   // Status
   output logic tx_paused_out,
   output logic rx_throttled_out
);
   typedef struct packed {
      logic tx_en;
      logic rx_en;
      logic tx_paused;
      logic rx_throttled;
      logic need_pause;
      logic need_resume;
      logic query_valid;
      logic query_value;
      logic ser_valid;
      logic [7:0] ser_data;
   } sfc_flow_state_t;

   sfc_flow_state_t s_q;
   sfc_flow_state_t s_d;
   logic buf_valid;
   logic [7:0] buf_data;
   logic buf_take;
   logic ser_free;
   logic ctrl_pending;

   function automatic logic is_char(input logic v, input logic [7:0] d, input logic [7:0] c);
      is_char = v && (d == c);
   endfunction : is_char

   // Payload goes through a two-entry buffer so a stall by the line loses nothing
   sfc_skid u_skid (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .in_valid_in(pay_valid_in),
      .in_data_in(pay_data_in),
      .in_ready_out(pay_ready_out),
      .out_valid_out(buf_valid),
      .out_data_out(buf_data),
      .out_ready_in(buf_take)
   );

   assign ser_free = !s_q.ser_valid || ser_tx_ready_in;
   assign ctrl_pending = s_q.need_pause || s_q.need_resume;
   assign buf_take = ser_free && !ctrl_pending && buf_valid && !s_q.tx_paused;

   always_comb begin
      s_d = s_q;
      s_d.query_valid = 1'b0;
      if (s_q.ser_valid && ser_tx_ready_in) begin
         s_d.ser_valid = 1'b0;
      end
      if (online_reset_in) begin
         s_d.tx_en = 1'b0;
         s_d.rx_en = 1'b0;
         s_d.tx_paused = 1'b0;
         s_d.rx_throttled = 1'b0;
         s_d.need_pause = 1'b0;
         s_d.need_resume = 1'b0;
      end else if (cfg_in.op == SFC_CFG_SET) begin
         if (cfg_in.tx_present) begin
            s_d.tx_en = cfg_in.tx_value;
         end
         if (cfg_in.rx_present) begin
            s_d.rx_en = cfg_in.rx_value;
         end
      end else if (cfg_in.op == SFC_CFG_QUERY) begin
         s_d.query_valid = 1'b1;
         s_d.query_value = s_q.tx_en || s_q.rx_en;
      end
      // Transmit pausing by received characters
      if (!s_q.tx_en) begin
         s_d.tx_paused = 1'b0;
      end else if (is_char(ser_rx_valid_in, ser_rx_data_in, CHAR_PAUSE)) begin
         s_d.tx_paused = 1'b1;
      end else if (is_char(ser_rx_valid_in, ser_rx_data_in, CHAR_RESUME)) begin
         s_d.tx_paused = 1'b0;
      end
      if (online_reset_in) begin
         s_d.tx_paused = 1'b0;
      end
      // Receive throttling with hysteresis
      // Online reset must not queue a pause character on its way out
      if (!s_q.rx_en || online_reset_in) begin
         s_d.rx_throttled = 1'b0;
         s_d.need_pause = 1'b0;
         s_d.need_resume = 1'b0;
      end else if (!s_q.rx_throttled && rx_level_in >= RX_HIGH_MARK) begin
         s_d.rx_throttled = 1'b1;
         s_d.need_pause = 1'b1;
         s_d.need_resume = 1'b0;
      end else if (s_q.rx_throttled && rx_level_in <= RX_LOW_MARK) begin
         s_d.rx_throttled = 1'b0;
         s_d.need_resume = 1'b1;
         s_d.need_pause = 1'b0;
      end
      // Output mux: flow characters go ahead of payload, even while paused
      if (ser_free) begin
         if (s_q.need_pause) begin
            s_d.ser_valid = 1'b1;
            s_d.ser_data = CHAR_PAUSE;
            s_d.need_pause = 1'b0;
         end else if (s_q.need_resume) begin
            s_d.ser_valid = 1'b1;
            s_d.ser_data = CHAR_RESUME;
            s_d.need_resume = 1'b0;
         end else if (buf_take) begin
            s_d.ser_valid = 1'b1;
            s_d.ser_data = buf_data;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign query_valid_out = s_q.query_valid;
   assign query_value_out = s_q.query_value;
   assign tx_en_out = s_q.tx_en;
   assign rx_en_out = s_q.rx_en;
   assign ser_tx_valid_out = s_q.ser_valid;
   assign ser_tx_data_out = s_q.ser_data;
   assign tx_paused_out = s_q.tx_paused;
   assign rx_throttled_out = s_q.rx_throttled;

   // Assertions
   property p_pause_halts;
      @(posedge ref_clk_in) disable iff (rst_in)
      (s_q.tx_en && !online_reset_in && is_char(ser_rx_valid_in, ser_rx_data_in, CHAR_PAUSE))
      |=> s_q.tx_paused && !buf_take;
   endproperty
   a_pause_halts: assert property (p_pause_halts) else $error("pause did not halt");

   property p_resume;
      @(posedge ref_clk_in) disable iff (rst_in)
      (s_q.tx_en && s_q.tx_paused && is_char(ser_rx_valid_in, ser_rx_data_in, CHAR_RESUME))
      |=> !s_q.tx_paused;
   endproperty
   a_resume: assert property (p_resume) else $error("resume ignored");

   property p_no_pause_off;
      @(posedge ref_clk_in) disable iff (rst_in)
      !s_q.tx_en |=> !s_q.tx_paused;
   endproperty
   a_no_pause_off: assert property (p_no_pause_off) else $error("paused while off");

   sequence s_nearly_full;
      s_q.rx_en && !s_q.rx_throttled && rx_level_in >= RX_HIGH_MARK && !online_reset_in;
   endsequence
   property p_send_pause;
      @(posedge ref_clk_in) disable iff (rst_in)
      s_nearly_full ##1 (ser_free && s_q.rx_en) |=> s_q.ser_valid && s_q.ser_data == CHAR_PAUSE;
   endproperty
   a_send_pause: assert property (p_send_pause) else $error("pause not sent");

   property p_resume_mark;
      @(posedge ref_clk_in) disable iff (rst_in)
      (s_q.rx_en && s_q.rx_throttled && rx_level_in <= RX_LOW_MARK && !online_reset_in)
      |=> !s_q.rx_throttled && s_q.need_resume;
   endproperty
   a_resume_mark: assert property (p_resume_mark) else $error("resume not queued");

   property p_hyst;
      @(posedge ref_clk_in) disable iff (rst_in)
      (s_q.rx_en && s_q.rx_throttled && rx_level_in > RX_LOW_MARK && !online_reset_in)
      |=> s_q.rx_throttled;
   endproperty
   a_hyst: assert property (p_hyst) else $error("throttle dropped early");

   property p_partial_cfg;
      @(posedge ref_clk_in) disable iff (rst_in)
      (cfg_in.op == SFC_CFG_SET && !cfg_in.tx_present && !online_reset_in)
      |=> $stable(s_q.tx_en);
   endproperty
   a_partial_cfg: assert property (p_partial_cfg) else $error("tx setting changed");

   property p_query;
      @(posedge ref_clk_in) disable iff (rst_in)
      (cfg_in.op == SFC_CFG_QUERY && !online_reset_in)
      |=> query_valid_out && query_value_out == $past(s_q.tx_en || s_q.rx_en);
   endproperty
   a_query: assert property (p_query) else $error("query answer wrong");

   property p_persist;
      @(posedge ref_clk_in) disable iff (rst_in)
      (cfg_in.op != SFC_CFG_SET && !online_reset_in) |=> $stable(s_q.tx_en) && $stable(s_q.rx_en);
   endproperty
   a_persist: assert property (p_persist) else $error("setting drifted");

   property p_onl_clear;
      @(posedge ref_clk_in) disable iff (rst_in)
      online_reset_in |=> !s_q.tx_en && !s_q.rx_en && !s_q.tx_paused && !s_q.rx_throttled;
   endproperty
   a_onl_clear: assert property (p_onl_clear) else $error("online left state");

   property p_rx_idle;
      @(posedge ref_clk_in) disable iff (rst_in)
      !s_q.rx_en |=> !s_q.rx_throttled && !s_q.need_pause && !s_q.need_resume;
   endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("rx off not idle");

   property p_pause_block;
      @(posedge ref_clk_in) disable iff (rst_in)
      s_q.tx_paused |-> !buf_take;
   endproperty
   a_pause_block: assert property (p_pause_block) else $error("sent while paused");

   sequence s_resume_queued;
      s_q.need_resume && !s_q.need_pause;
   endsequence
   property p_send_resume;
      @(posedge ref_clk_in) disable iff (rst_in)
      (s_resume_queued ##0 ser_free) |=> s_q.ser_valid && s_q.ser_data == CHAR_RESUME;
   endproperty
   a_send_resume: assert property (p_send_resume) else $error("resume not sent");

   property p_char_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      (s_q.ser_valid && !ser_tx_ready_in) |=> s_q.ser_valid && $stable(s_q.ser_data);
   endproperty
   a_char_hold: assert property (p_char_hold) else $error("char not held");

   property p_ctrl_first;
      @(posedge ref_clk_in) disable iff (rst_in)
      ctrl_pending |-> !buf_take;
   endproperty
   a_ctrl_first: assert property (p_ctrl_first) else $error("char overtaken");

   property p_set_tx;
      @(posedge ref_clk_in) disable iff (rst_in)
      (cfg_in.op == SFC_CFG_SET && cfg_in.tx_present && !online_reset_in)
      |=> s_q.tx_en == $past(cfg_in.tx_value);
   endproperty
   a_set_tx: assert property (p_set_tx) else $error("tx not set");

   property p_set_rx;
      @(posedge ref_clk_in) disable iff (rst_in)
      (cfg_in.op == SFC_CFG_SET && cfg_in.rx_present && !online_reset_in)
      |=> s_q.rx_en == $past(cfg_in.rx_value);
   endproperty
   a_set_rx: assert property (p_set_rx) else $error("rx not set");

   property p_partial_rx;
      @(posedge ref_clk_in) disable iff (rst_in)
      (cfg_in.op == SFC_CFG_SET && !cfg_in.rx_present && !online_reset_in)
      |=> $stable(s_q.rx_en);
   endproperty
   a_partial_rx: assert property (p_partial_rx) else $error("rx setting changed");

   property p_query_pulse;
      @(posedge ref_clk_in) disable iff (rst_in)
      (cfg_in.op != SFC_CFG_QUERY || online_reset_in) |=> !query_valid_out;
   endproperty
   a_query_pulse: assert property (p_query_pulse) else $error("stray answer");

   property p_thr_rise;
      @(posedge ref_clk_in) disable iff (rst_in)
      (!s_q.rx_throttled && rx_level_in < RX_HIGH_MARK) |=> !s_q.rx_throttled;
   endproperty
   a_thr_rise: assert property (p_thr_rise) else $error("early throttle");

   property p_off_ignore;
      @(posedge ref_clk_in) disable iff (rst_in)
      (!s_q.tx_en && is_char(ser_rx_valid_in, ser_rx_data_in, CHAR_PAUSE)) |=> !s_q.tx_paused;
   endproperty
   a_off_ignore: assert property (p_off_ignore) else $error("char seen while off");
endmodule : sfc_flow

/* sfc_peer.sv */
// Purpose: Serial device model facing the flow control block
// Assumes: Byte link in the block's clock domain
// Notes: Idle receive data shows the inverse of the last byte
`timescale 1ns/1ns
module sfc_peer
   import sfc_pkg::*;
(
   // Clock
   input wire logic ref_clk_in,
   // Link towards the block
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_ready_out,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   // Test control
   input wire logic stall_in
);
   logic [7:0] got_q[$];
   initial begin
      tx_ready_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_data_out = 8'h00;
   end
   // Stalling keeps the block's byte waiting on the line
   always @(posedge ref_clk_in) begin
      if (tx_valid_in && tx_ready_out) begin
         got_q.push_back(tx_data_in);
      end
      tx_ready_out <= !stall_in;
   end
   task automatic send_char(input logic [7:0] c);
      @(posedge ref_clk_in);
      rx_valid_out <= 1'b1;
      rx_data_out <= c;
      @(posedge ref_clk_in);
      rx_valid_out <= 1'b0;
      rx_data_out <= ~c;
   endtask : send_char
endmodule : sfc_peer

/* test_serial_soft_flow_control.sv */
// Purpose: Self-checking test of the flow control block
// Assumes: Two-entry skid ahead of the output register
// Notes: Payload comes from a small source memory
`timescale 1ns/1ns
module test_serial_soft_flow_control
   import sfc_pkg::*;
;
   logic clk, rst, online, q_valid, q_value, tx_en, rx_en, stall;
   logic pay_valid, pay_ready, s_valid, s_ready, r_valid, paused, thr;
   logic [7:0] pay_data, s_data, r_data;
   logic [7:0] src[16];
   logic [6:0] level;
   sfc_cfg_t cfg;
   int wr, rd, num_errors, checks;
   sfc_flow uut (
      .ref_clk_in(clk), .rst_in(rst), .cfg_in(cfg), .online_reset_in(online),
      .query_valid_out(q_valid), .query_value_out(q_value), .tx_en_out(tx_en),
      .rx_en_out(rx_en), .pay_valid_in(pay_valid), .pay_data_in(pay_data),
      .pay_ready_out(pay_ready), .ser_tx_valid_out(s_valid), .ser_tx_data_out(s_data),
      .ser_tx_ready_in(s_ready), .ser_rx_valid_in(r_valid), .ser_rx_data_in(r_data),
      .rx_level_in(level), .tx_paused_out(paused), .rx_throttled_out(thr)
   );
   sfc_peer peer (
      .ref_clk_in(clk), .tx_valid_in(s_valid), .tx_data_in(s_data),
      .tx_ready_out(s_ready), .rx_valid_out(r_valid), .rx_data_out(r_data),
      .stall_in(stall)
   );
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Payload source holds each byte until the block takes it
   always @(posedge clk) begin
      if (pay_valid && pay_ready) begin
         rd = rd + 1;
      end
      pay_valid <= (rd < wr);
      pay_data <= src[rd[3:0]];
   end
   task automatic print_verdict;
      $display("Checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic push(input logic [7:0] b);
      @(posedge clk);
      src[wr[3:0]] <= b;
      wr <= wr + 1;
   endtask : push
   task automatic sendc(input logic [7:0] c);
      peer.send_char(c);
      #1;
   endtask : sendc
   task automatic cmd(input sfc_cfg_op_t op, input logic [3:0] f);
      @(posedge clk);
      cfg <= {op, f};
      @(posedge clk);
      cfg <= {SFC_CFG_NONE, 4'h0};
      #1;
   endtask : cmd
   task automatic exp_byte(input logic [7:0] e);
      int n;
      n = 0;
      while (peer.got_q.size() == 0 && n < 200) begin
         tick(1);
         n++;
      end
      if (n == 200) begin
         num_errors++;
         print_verdict();
      end
      chk("serial byte", e, peer.got_q.pop_front());
   endtask : exp_byte
   task automatic t_reset;
      chk("tx enable", 8'h00, tx_en);
      chk("rx enable", 8'h00, rx_en);
      chk("pay ready", 8'h01, pay_ready);
      cmd(SFC_CFG_QUERY, 4'h0);
      chk("query valid", 8'h01, q_valid);
      chk("query value", 8'h00, q_value);
   endtask : t_reset
   task automatic t_tx_off;
      sendc(CHAR_PAUSE);
      chk("paused", 8'h00, paused);
      push(CHAR_PAUSE);
      push(CHAR_RESUME);
      exp_byte(CHAR_PAUSE);
      exp_byte(CHAR_RESUME);
   endtask : t_tx_off
   task automatic t_pause;
      cmd(SFC_CFG_SET, 4'hC);
      chk("tx enable", 8'h01, tx_en);
      chk("rx enable", 8'h00, rx_en);
      stall <= 1'b1;
      push(8'hA1);
      tick(6);
      sendc(CHAR_PAUSE);
      chk("paused", 8'h01, paused);
      push(8'hA2);
      push(8'hA3);
      push(8'hA4);
      stall <= 1'b0;
      tick(20);
      exp_byte(8'hA1);
      chk("held count", 8'h00, 8'(peer.got_q.size()));
      chk("pay ready", 8'h00, pay_ready);
      sendc(CHAR_RESUME);
      chk("paused", 8'h00, paused);
      exp_byte(8'hA2);
      exp_byte(8'hA3);
      exp_byte(8'hA4);
   endtask : t_pause
   task automatic t_throttle;
      cmd(SFC_CFG_SET, 4'h3);
      chk("tx enable", 8'h01, tx_en);
      chk("rx enable", 8'h01, rx_en);
      level <= RX_HIGH_MARK - 7'h01;
      tick(10);
      chk("throttled", 8'h00, thr);
      chk("sent count", 8'h00, 8'(peer.got_q.size()));
      level <= RX_HIGH_MARK;
      exp_byte(CHAR_PAUSE);
      chk("throttled", 8'h01, thr);
      level <= RX_LOW_MARK + 7'h01;
      tick(10);
      chk("throttled", 8'h01, thr);
      chk("sent count", 8'h00, 8'(peer.got_q.size()));
      level <= RX_LOW_MARK;
      exp_byte(CHAR_RESUME);
      chk("throttled", 8'h00, thr);
      cmd(SFC_CFG_QUERY, 4'h0);
      chk("query valid", 8'h01, q_valid);
      chk("query value", 8'h01, q_value);
      chk("tx enable", 8'h01, tx_en);
   endtask : t_throttle
   task automatic t_online;
      online <= 1'b1;
      tick(1);
      online <= 1'b0;
      chk("tx enable", 8'h00, tx_en);
      chk("rx enable", 8'h00, rx_en);
      cmd(SFC_CFG_QUERY, 4'h0);
      chk("query value", 8'h00, q_value);
   endtask : t_online
   initial begin
      rst = 1'b1;
      online = 1'b0;
      cfg = {SFC_CFG_NONE, 4'h0};
      level = 7'h00;
      stall = 1'b0;
      pay_valid = 1'b0;
      pay_data = 8'h00;
      {wr, rd, num_errors, checks} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      t_reset();
      t_tx_off();
      t_pause();
      t_throttle();
      t_online();
      print_verdict();
   end
endmodule : test_serial_soft_flow_control
